// *** src/sms_map.svh ***
// register map, reset values and timing counts of the sleep sequencer
//
// Functional notes
// - writing force_sleep_bit starts sleep entry; hardware clears it during sleep
// - main supply fault or battery fault start sleep entry identically
// - first shutdown step copies gpio_sleep_state_reg into the gpio output data
// - first step drives all dram strobes low once memory is idle; second step drives them low regardless
// - fault entry overrides wake sources with the fault state, lines 0 and 1 only
// - second step clears gpio edge detects and the rtc alarm
// - second step applies internal reset and asserts system_reset_out
// - third step stops the oscillator only when osc_powerdown_enable is set
// - third step drops core_power_enable_out; the supply then switches off
// - each shutdown step lasts one 32.768 kHz period
// - wake event in sleep only counts without battery fault; supply fault ignored
// - first wake step raises core power, starts 10 ms ramp, restarts oscillator
// - battery fault during wake-up returns to sleep through the fault state
// - 150 ms oscillator wait follows the ramp, skipped when powerdown is off
// - any fault during the oscillator wait returns through the fault state
// - third wake step releases internal reset and system_reset_out
// - fault state clears wake sources, loads wake enables with 3 and sets bits 0 and 1 of the edge enables
// - reset cause register tells sleep, software, watchdog and hardware reset
// - sleep cause register holds sticky supply, battery and force-sleep flags
// - scratch register is read/write, survives sleep, unused by hardware
// - hard reset in sleep clears force sleep, powers up, times pll, boots
// - dram strobes stay low after sleep until software clears dram_hold_bit
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_OFS_CTRL    8'h00
`define SMS_OFS_CFG     8'h04
`define SMS_OFS_STAT    8'h08
`define SMS_OFS_SCAUSE  8'h0C
`define SMS_OFS_SCRATCH 8'h10
`define SMS_OFS_RCAUSE  8'h14
`define SMS_OFS_WAKE    8'h18
`define SMS_OFS_RISE    8'h1C
`define SMS_OFS_FALL    8'h20
`define SMS_OFS_GSLEEP  8'h24
`define SMS_BIT_FS      0
`define SMS_BIT_OSC_POWERDOWN_ENABLE    0
`define SMS_BIT_DH      0
`define SMS_POS_STATE   4
`define SMS_BIT_RTC     31
`define SMS_WAKE_RST    32'h0000_0003
`define SMS_EDGE_RST    32'h0000_0003
`define SMS_CLK_NS      40
`define SMS_STEP_NS     30518
`define SMS_STEP_CYC    ((`SMS_STEP_NS + `SMS_CLK_NS - 1) / `SMS_CLK_NS)
`define SMS_RAMP_MS     10
`define SMS_RAMP_CYC    (`SMS_RAMP_MS * 1000000 / `SMS_CLK_NS)
`define SMS_OSC_MS      150
`define SMS_OSC_CYC     (`SMS_OSC_MS * 1000000 / `SMS_CLK_NS)
`define SMS_PLL_US      150
`define SMS_PLL_CYC     (`SMS_PLL_US * 1000 / `SMS_CLK_NS)
`endif

// *** src/sms_pkg.sv ***
// types of the sleep sequencer
package sms_pkg;
  typedef enum logic [3:0] {
    SMS_RUN   = 4'h0,
    SMS_SD1   = 4'h1,
    SMS_SD2   = 4'h2,
    SMS_SD3   = 4'h3,
    SMS_SLEEP = 4'h4,
    SMS_WK1   = 4'h5,
    SMS_WK2   = 4'h6,
    SMS_WK3   = 4'h7,
    SMS_FAULT = 4'h8,
    SMS_HRST  = 4'h9,
    SMS_PLL   = 4'hA
  } sms_state_t;
endpackage

// *** src/sms_sleep_seq.sv ***
// sleep-mode sequencer with apb register file
`timescale 1ns/1ns
`include "sms_map.svh"
module sms_sleep_seq import sms_pkg::*; #(
  parameter int              GW       = 28,
  parameter int              CW       = 22,
  parameter logic [CW-1:0]   STEP_CYC = CW'(`SMS_STEP_CYC),
  parameter logic [CW-1:0]   RAMP_CYC = CW'(`SMS_RAMP_CYC),
  parameter logic [CW-1:0]   OSC_CYC  = CW'(`SMS_OSC_CYC),
  parameter logic [CW-1:0]   PLL_CYC  = CW'(`SMS_PLL_CYC)
) (
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          main_supply_fault_in,
  input  wire logic          battery_fault_in,
  input  wire logic          hard_reset_in_n,
  input  wire logic          sw_reset_in,
  input  wire logic          wdog_reset_in,
  input  wire logic          mem_idle_in,
  input  wire logic          rtc_alarm_in,
  input  wire logic [GW-1:0] gpio_in,
  output logic [GW-1:0]      gpio_out_data,
  output logic               gpio_out_load,
  output logic               edge_clear_out,
  output logic [3:0]         row_strobe_n,
  output logic [3:0]         col_strobe_n,
  output logic               int_reset_out,
  output logic               system_reset_out,
  output logic               osc_enable_out,
  output logic               core_power_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  sms_state_t      state_ff;
  logic [CW-1:0]   cnt_ff;
  logic            fault_ff;
  logic            fs_ff;
  logic            osc_powerdown_enable_ff;
  logic            dh_ff;
  logic [2:0]      scause_ff;
  logic [3:0]      rcause_ff;
  logic [31:0]     scratch_ff;
  logic [31:0]     wake_en_ff;
  logic [31:0]     rise_en_ff;
  logic [31:0]     fall_en_ff;
  logic [GW-1:0]   gsleep_ff;
  logic [GW-1:0]   prev_ff;
  logic [GW-1:0]   edge_ff;
  logic            alarm_ff;
  logic [GW-1:0]   gout_ff;
  logic            gload_ff;
  logic            clr_ff;
  logic            int_rst_ff;
  logic            sys_rst_ff;
  logic            osc_en_ff;
  logic            pwr_ff;
  logic [31:0]     prdata_ff;
  logic            pready_ff;
  logic            pslverr_ff;
  logic [31:0]     rd_mux;
  logic            acc;
  logic            wr;
  logic            done;
  logic            wake_ev;
  logic            any_fault;
  logic            go_fault;

  // a step, timer or lock wait ends when the counter reaches its limit
  function automatic logic [CW-1:0] lim(input sms_state_t s);
    case (s)
      SMS_WK1: lim = RAMP_CYC - 1'b1;
      SMS_WK2: lim = OSC_CYC - 1'b1;
      SMS_PLL: lim = PLL_CYC - 1'b1;
      default: lim = STEP_CYC - 1'b1;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a);
    case (a)
      `SMS_OFS_CTRL, `SMS_OFS_CFG, `SMS_OFS_STAT, `SMS_OFS_SCAUSE,
      `SMS_OFS_SCRATCH, `SMS_OFS_RCAUSE, `SMS_OFS_WAKE, `SMS_OFS_RISE,
      `SMS_OFS_FALL, `SMS_OFS_GSLEEP: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  endfunction

  function automatic logic wsel(input logic [7:0] ofs);
    wsel = wr && paddr == ofs;
  endfunction

  assign acc       = psel & penable;
  assign wr        = acc & pready_ff & pwrite;
  assign done      = cnt_ff == lim(state_ff);
  assign any_fault = main_supply_fault_in | battery_fault_in;
  // supply fault is not watched in sleep: the core supply is off then
  assign wake_ev   = (|(edge_ff & wake_en_ff[GW-1:0]))
                   | (alarm_ff & wake_en_ff[`SMS_BIT_RTC]);
  assign go_fault  = (state_ff inside {SMS_WK1, SMS_WK2, SMS_WK3} && battery_fault_in)
                   || (state_ff == SMS_WK2 && main_supply_fault_in);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= SMS_RUN;
      cnt_ff   <= '0;
      fault_ff <= 1'b0;
    end else if (!hard_reset_in_n) begin
      state_ff <= SMS_HRST;
      cnt_ff   <= '0;
      fault_ff <= 1'b0;
    end else begin
      cnt_ff <= done ? '0 : cnt_ff + 1'b1;
      case (state_ff)
        SMS_RUN: begin
          cnt_ff <= '0;
          if (fs_ff || any_fault) begin
            state_ff <= SMS_SD1;
            fault_ff <= any_fault;
          end
        end
        SMS_SD1: if (done) state_ff <= SMS_SD2;
        SMS_SD2: if (done) state_ff <= SMS_SD3;
        SMS_SD3: if (done) state_ff <= SMS_SLEEP;
        SMS_SLEEP: begin
          cnt_ff <= '0;
          if (wake_ev && !battery_fault_in) state_ff <= SMS_WK1;
        end
        SMS_WK1: begin
          if (go_fault) begin
            state_ff <= SMS_FAULT;
          end else if (done) begin
            state_ff <= osc_powerdown_enable_ff ? SMS_WK2 : SMS_WK3;
          end
        end
        SMS_WK2: begin
          if (go_fault) state_ff <= SMS_FAULT;
          else if (done) state_ff <= SMS_WK3;
        end
        SMS_WK3: begin
          if (go_fault) begin
            state_ff <= SMS_FAULT;
          end else if (done) begin
            state_ff <= SMS_RUN;
            fault_ff <= 1'b0;
          end
        end
        SMS_FAULT: begin
          state_ff <= SMS_SD1;
          cnt_ff   <= '0;
          fault_ff <= 1'b1;
        end
        SMS_HRST: begin
          state_ff <= SMS_PLL;
          cnt_ff   <= '0;
        end
        SMS_PLL: if (done) state_ff <= SMS_RUN;
        default: state_ff <= SMS_RUN;
      endcase
      if (go_fault) cnt_ff <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins driven by the sequence

  always_ff @(posedge mclk) begin
    if (srst) begin
      gout_ff  <= '0;
      gload_ff <= 1'b0;
      clr_ff   <= 1'b0;
    end else begin
      gload_ff <= state_ff == SMS_SD1 && cnt_ff == '0;
      if (state_ff == SMS_SD1 && cnt_ff == '0) gout_ff <= gsleep_ff;
      clr_ff   <= (state_ff == SMS_SD2 && cnt_ff == '0) || state_ff == SMS_FAULT;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      int_rst_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
    end else if (state_ff == SMS_SD2 || state_ff == SMS_HRST) begin
      int_rst_ff <= 1'b1;
      sys_rst_ff <= 1'b1;
    end else if ((state_ff == SMS_WK3 || state_ff == SMS_PLL) && done && !go_fault
                 && hard_reset_in_n) begin
      // cpu fetch can only start after the internal reset drops, so both go together
      int_rst_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pwr_ff    <= 1'b1;
      osc_en_ff <= 1'b1;
    end else if (state_ff inside {SMS_WK1, SMS_HRST}) begin
      pwr_ff    <= 1'b1;
      osc_en_ff <= 1'b1;
    end else if (state_ff == SMS_SD3) begin
      pwr_ff <= 1'b0;
      if (osc_powerdown_enable_ff) osc_en_ff <= 1'b0;
    end
  end

  // dram hold: low strobes survive the reset and the wake-up
  always_ff @(posedge mclk) begin
    if (srst) begin
      dh_ff <= 1'b0;
    end else if ((state_ff == SMS_SD1 && mem_idle_in) || state_ff == SMS_SD2) begin
      dh_ff <= 1'b1;
    end else if (wsel(`SMS_OFS_STAT) && pwdata[`SMS_BIT_DH]) begin
      dh_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_ff  <= '0;
      edge_ff  <= '0;
      alarm_ff <= 1'b0;
    end else begin
      prev_ff <= gpio_in;
      if (state_ff == SMS_SD2 || state_ff == SMS_FAULT) begin
        edge_ff  <= '0;
        alarm_ff <= 1'b0;
      end else begin
        edge_ff  <= edge_ff | (gpio_in & ~prev_ff & rise_en_ff[GW-1:0])
                          | (~gpio_in & prev_ff & fall_en_ff[GW-1:0]);
        alarm_ff <= alarm_ff | rtc_alarm_in;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_en_ff <= `SMS_WAKE_RST;
      rise_en_ff <= `SMS_EDGE_RST;
      fall_en_ff <= `SMS_EDGE_RST;
    end else if ((state_ff == SMS_SD1 && fault_ff) || state_ff == SMS_FAULT) begin
      wake_en_ff <= `SMS_WAKE_RST;
      rise_en_ff <= rise_en_ff | `SMS_EDGE_RST;
      fall_en_ff <= fall_en_ff | `SMS_EDGE_RST;
    end else begin
      if (wsel(`SMS_OFS_WAKE)) wake_en_ff <= pwdata;
      if (wsel(`SMS_OFS_RISE)) rise_en_ff <= pwdata;
      if (wsel(`SMS_OFS_FALL)) fall_en_ff <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge mclk) begin
    if (srst) begin
      fs_ff <= 1'b0;
    end else if (state_ff inside {SMS_SLEEP, SMS_HRST}) begin
      fs_ff <= 1'b0;
    end else if (wsel(`SMS_OFS_CTRL)) begin
      fs_ff <= pwdata[`SMS_BIT_FS];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_powerdown_enable_ff    <= 1'b0;
      scratch_ff <= '0;
      gsleep_ff  <= '0;
    end else begin
      if (wsel(`SMS_OFS_CFG)) osc_powerdown_enable_ff <= pwdata[`SMS_BIT_OSC_POWERDOWN_ENABLE];
      if (wsel(`SMS_OFS_SCRATCH)) scratch_ff <= pwdata;
      if (wsel(`SMS_OFS_GSLEEP)) gsleep_ff <= pwdata[GW-1:0];
    end
  end

  // sticky causes: write one to clear, a new event in the same cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      scause_ff <= '0;
      rcause_ff <= '0;
    end else begin
      scause_ff <= (scause_ff & ~({3{wsel(`SMS_OFS_SCAUSE)}} & pwdata[2:0]))
                 | ({3{state_ff == SMS_RUN}}
                    & {fs_ff, battery_fault_in, main_supply_fault_in})
                 | {1'b0, go_fault & battery_fault_in, go_fault & main_supply_fault_in};
      rcause_ff <= (rcause_ff & ~({4{wsel(`SMS_OFS_RCAUSE)}} & pwdata[3:0]))
                 | {state_ff == SMS_WK3 && done && !go_fault && hard_reset_in_n,
                    wdog_reset_in, sw_reset_in, !hard_reset_in_n};
    end
  end

  always_comb begin
    case (paddr)
      `SMS_OFS_CTRL:    rd_mux = {31'h0, fs_ff};
      `SMS_OFS_CFG:     rd_mux = {31'h0, osc_powerdown_enable_ff};
      `SMS_OFS_STAT:    rd_mux = {24'h0, state_ff, 3'h0, dh_ff};
      `SMS_OFS_SCAUSE:  rd_mux = {29'h0, scause_ff};
      `SMS_OFS_SCRATCH: rd_mux = scratch_ff;
      `SMS_OFS_RCAUSE:  rd_mux = {28'h0, rcause_ff};
      `SMS_OFS_WAKE:    rd_mux = wake_en_ff;
      `SMS_OFS_RISE:    rd_mux = rise_en_ff;
      `SMS_OFS_FALL:    rd_mux = fall_en_ff;
      `SMS_OFS_GSLEEP:  rd_mux = 32'(gsleep_ff);
      default:          rd_mux = 32'h0;
    endcase
  end

  // apb: one wait state, so data and error come straight from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~hit(paddr);
      prdata_ff  <= (acc & ~pready_ff & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  assign prdata                = prdata_ff;
  assign pready                = pready_ff;
  assign pslverr               = pslverr_ff;
  assign gpio_out_data         = gout_ff;
  assign gpio_out_load         = gload_ff;
  assign edge_clear_out        = clr_ff;
  assign row_strobe_n          = {4{~dh_ff}};
  assign col_strobe_n          = {4{~dh_ff}};
  assign int_reset_out         = int_rst_ff;
  assign system_reset_out      = sys_rst_ff;
  assign osc_enable_out        = osc_en_ff;
  assign core_power_enable_out = pwr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  chk_force_entry: assert property (
    state_ff == SMS_RUN && fs_ff && hard_reset_in_n |=> state_ff == SMS_SD1)
    else $error("force sleep did not start shutdown");
  chk_fault_entry: assert property (
    state_ff == SMS_RUN && any_fault && hard_reset_in_n |=> state_ff == SMS_SD1 && fault_ff)
    else $error("fault did not start shutdown");
  chk_gpio_copy: assert property (
    state_ff == SMS_SD1 && cnt_ff == '0 |=> gload_ff && gout_ff == $past(gsleep_ff))
    else $error("sleep levels not copied");
  chk_dram_low: assert property (
    state_ff == SMS_SD3 |-> row_strobe_n == 4'h0 && col_strobe_n == 4'h0)
    else $error("dram strobes not low");
  chk_fault_wake: assert property (
    state_ff == SMS_SD2 && fault_ff |-> wake_en_ff == `SMS_WAKE_RST)
    else $error("fault wake state not applied");
  chk_sd2_clear: assert property (
    state_ff == SMS_SD2 && cnt_ff == '0 |=> clr_ff ##1 edge_ff == '0)
    else $error("wake sources not cleared");
  chk_sd2_reset: assert property (
    state_ff == SMS_SD2 |=> int_rst_ff && sys_rst_ff)
    else $error("internal reset not applied");
  chk_osc_keep: assert property (
    state_ff == SMS_SD3 && !osc_powerdown_enable_ff |=> osc_en_ff)
    else $error("oscillator stopped without powerdown");
  chk_pwr_drop: assert property (
    state_ff == SMS_SLEEP |-> !pwr_ff)
    else $error("core power on in sleep");
  chk_step_len: assert property (
    $rose(state_ff == SMS_SD2) |-> cnt_ff == '0 && $past(cnt_ff) == STEP_CYC - 1'b1)
    else $error("shutdown step length wrong");
  chk_batt_block: assert property (
    state_ff == SMS_SLEEP && battery_fault_in && hard_reset_in_n |=> state_ff == SMS_SLEEP)
    else $error("wake taken under battery fault");
  chk_wake_pwr: assert property (
    $rose(state_ff == SMS_WK1) |=> pwr_ff && osc_en_ff)
    else $error("wake did not power up");
  chk_osc_skip: assert property (
    state_ff == SMS_WK1 && done && !osc_powerdown_enable_ff && !go_fault && hard_reset_in_n
    |=> state_ff == SMS_WK3)
    else $error("oscillator wait not skipped");

  cov_full_cycle: cover property (state_ff == SMS_WK3 ##1 state_ff == SMS_RUN);
  cov_fault_back: cover property (state_ff == SMS_FAULT ##1 state_ff == SMS_SD1);
  cov_hard_boot:  cover property (state_ff == SMS_PLL ##1 state_ff == SMS_RUN);

endmodule

// *** test/sms_supply_model.sv ***
// external core supply with its fault detectors, as seen by the sequencer
`timescale 1ns/1ns
module sms_supply_model (
  input  wire logic mclk,
  input  wire logic core_power_enable_out,
  input  wire logic main_cmd,
  input  wire logic batt_cmd,
  output logic      main_supply_fault_in,
  output logic      battery_fault_in
);
  logic [2:0] ramp_ff = 3'h4;
  ////////////////////////////////////////////////////////////////////////////////
  // rail switches off on a low enable and needs four cycles to come back
  always_ff @(posedge mclk) begin
    if (core_power_enable_out !== 1'b1) begin
      ramp_ff <= 3'h0;
    end else if (ramp_ff != 3'h4) begin
      ramp_ff <= ramp_ff + 3'h1;
    end
  end
  // an unpowered rail reads as out of regulation, so the sequencer must ignore it then
  assign main_supply_fault_in = main_cmd | (ramp_ff != 3'h4);
  assign battery_fault_in     = batt_cmd;
endmodule

// *** test/tb_top.sv ***
// self-checking bench of the sleep sequencer
`timescale 1ns/1ns
`include "sms_map.svh"
module tb_top import sms_pkg::*; ;
  localparam logic [21:0] STEP = 22'h4;
  localparam logic [21:0] RAMP = 22'h8;
  localparam logic [21:0] OSC  = 22'hA;
  localparam logic [21:0] PLL  = 22'h6;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, main_cmd, batt_cmd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        main_supply_fault_in, battery_fault_in, hard_reset_in_n, sw_reset_in;
  logic        wdog_reset_in, mem_idle_in, rtc_alarm_in, gpio_out_load, edge_clear_out;
  logic        int_reset_out, system_reset_out, osc_enable_out, core_power_enable_out;
  logic [27:0] gpio_in, gpio_out_data;
  logic [3:0]  row_strobe_n, col_strobe_n;
  logic        rst_q = 1'b0;
  logic        core_q = 1'b0;
  int          cyc, t_load, t_rst_up, t_rst_dn, t_core_dn, t_core_up, n_clr;
  int          fails, samples_checked;
  ////////////////////////////////////////////////////////////////////////////////
  sms_sleep_seq #(.STEP_CYC(STEP), .RAMP_CYC(RAMP), .OSC_CYC(OSC), .PLL_CYC(PLL)) i_dut (
    .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .main_supply_fault_in, .battery_fault_in, .hard_reset_in_n, .sw_reset_in,
    .wdog_reset_in, .mem_idle_in, .rtc_alarm_in, .gpio_in, .gpio_out_data, .gpio_out_load,
    .edge_clear_out, .row_strobe_n, .col_strobe_n, .int_reset_out, .system_reset_out,
    .osc_enable_out, .core_power_enable_out);
  sms_supply_model i_sup (.mclk, .core_power_enable_out, .main_cmd, .batt_cmd,
    .main_supply_fault_in, .battery_fault_in);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // edge stamps, all taken from values sampled at the same rising edge
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rst_q <= int_reset_out;
    core_q <= core_power_enable_out;
    if (gpio_out_load === 1'b1) t_load <= cyc;
    if (edge_clear_out === 1'b1) n_clr <= n_clr + 1;
    if (int_reset_out === 1'b1 && rst_q === 1'b0) t_rst_up <= cyc;
    if (int_reset_out === 1'b0 && rst_q === 1'b1) t_rst_dn <= cyc;
    if (core_power_enable_out === 1'b0 && core_q === 1'b1) t_core_dn <= cyc;
    if (core_power_enable_out === 1'b1 && core_q === 1'b0) t_core_up <= cyc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // one wait state: the access phase lasts two cycles
    chk("apb access cycles", 32'h2, 32'(n));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(w, x, r & m);
  endtask
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core_power_enable_out !== lvl && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("core power", 32'(lvl), 32'(core_power_enable_out));
    repeat (4) @(posedge mclk);
  endtask
  task automatic gp(input int i, input logic v);
    @(posedge mclk);
    gpio_in[i] <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rdc("wake enable", `SMS_OFS_WAKE, 32'hFFFF_FFFF, 32'h0000_0003);
    rdc("rise enable", `SMS_OFS_RISE, 32'hFFFF_FFFF, 32'h0000_0003);
    rdc("fall enable", `SMS_OFS_FALL, 32'hFFFF_FFFF, 32'h0000_0003);
    rdc("osc powerdown", `SMS_OFS_CFG, 32'h1, 32'h0);
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    $display("test reset done");
  endtask
  task automatic t_force;
    int c0;
    c0 = n_clr;
    wr(`SMS_OFS_SCRATCH, 32'h5A5A_C3C3);
    wr(`SMS_OFS_GSLEEP, 32'h0A5A_5A5A);
    wr(`SMS_OFS_CFG, 32'h1);
    mem_idle_in <= 1'b0;
    wr(`SMS_OFS_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    chk("strobes busy", 32'hFF, 32'({row_strobe_n, col_strobe_n}));
    mem_idle_in <= 1'b1;
    wait_core(1'b0);
    chk("load to reset", 32'(STEP), 32'(t_rst_up - t_load));
    chk("load to power off", 32'(2 * STEP), 32'(t_core_dn - t_load));
    chk("sleep levels", 32'h0A5A_5A5A, 32'(gpio_out_data));
    chk("strobes", 32'h0, 32'({row_strobe_n, col_strobe_n}));
    chk("oscillator", 32'h0, 32'(osc_enable_out));
    chk("system reset", 32'h1, 32'(system_reset_out));
    chk("edge clears", 32'h1, 32'(n_clr - c0));
    rdc("state", `SMS_OFS_STAT, 32'hF0, {24'h0, SMS_SLEEP, 4'h0});
    gp(0, 1'b1);
    wait_core(1'b1);
    repeat (30) @(posedge mclk);
    // power rises a cycle into the first step, reset drops as the last step ends
    chk("wake time", 32'(RAMP + OSC + STEP - 1), 32'(t_rst_dn - t_core_up));
    chk("oscillator", 32'h1, 32'(osc_enable_out));
    chk("system reset", 32'h0, 32'(system_reset_out));
    rdc("force sleep", `SMS_OFS_CTRL, 32'h1, 32'h0);
    rdc("reset cause", `SMS_OFS_RCAUSE, 32'hF, 32'h8);
    rdc("sleep cause", `SMS_OFS_SCAUSE, 32'h7, 32'h4);
    rdc("scratch", `SMS_OFS_SCRATCH, 32'hFFFF_FFFF, 32'h5A5A_C3C3);
    chk("strobes held", 32'h0, 32'({row_strobe_n, col_strobe_n}));
    wr(`SMS_OFS_STAT, 32'h1);
    @(posedge mclk);
    chk("strobes free", 32'hFF, 32'({row_strobe_n, col_strobe_n}));
    wr(`SMS_OFS_SCAUSE, 32'h7);
    $display("test force sleep done");
  endtask
  task automatic t_fault;
    int c0;
    wr(`SMS_OFS_CFG, 32'h0);
    wr(`SMS_OFS_WAKE, 32'h4);
    batt_cmd <= 1'b1;
    wait_core(1'b0);
    chk("oscillator kept", 32'h1, 32'(osc_enable_out));
    rdc("fault wake enable", `SMS_OFS_WAKE, 32'hFFFF_FFFF, 32'h0000_0003);
    gp(0, 1'b0);
    repeat (12) @(posedge mclk);
    chk("power under fault", 32'h0, 32'(core_power_enable_out));
    batt_cmd <= 1'b0;
    gp(0, 1'b1);
    wait_core(1'b1);
    batt_cmd <= 1'b1;
    wait_core(1'b0);
    rdc("sleep cause", `SMS_OFS_SCAUSE, 32'h7, 32'h2);
    batt_cmd <= 1'b0;
    gp(1, 1'b1);
    wait_core(1'b1);
    repeat (20) @(posedge mclk);
    chk("short wake", 32'(RAMP + STEP - 1), 32'(t_rst_dn - t_core_up));
    wr(`SMS_OFS_CFG, 32'h1);
    main_cmd <= 1'b1;
    wait_core(1'b0);
    main_cmd <= 1'b0;
    gp(0, 1'b0);
    wait_core(1'b1);
    c0 = t_rst_dn;
    repeat (8) @(posedge mclk);
    main_cmd <= 1'b1;
    wait_core(1'b0);
    chk("no boot on supply fault", 32'(c0), 32'(t_rst_dn));
    rdc("sleep cause", `SMS_OFS_SCAUSE, 32'h1, 32'h1);
    main_cmd <= 1'b0;
    gp(0, 1'b1);
    wait_core(1'b1);
    repeat (30) @(posedge mclk);
    wr(`SMS_OFS_STAT, 32'h1);
    $display("test fault sleep done");
  endtask
  task automatic t_hard;
    wr(`SMS_OFS_RCAUSE, 32'hF);
    wr(`SMS_OFS_CTRL, 32'h1);
    wait_core(1'b0);
    hard_reset_in_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("power in hard reset", 32'h1, 32'(core_power_enable_out));
    hard_reset_in_n <= 1'b1;
    repeat (PLL + 4) @(posedge mclk);
    chk("boot after hard reset", 32'h0, 32'(int_reset_out));
    rdc("force sleep", `SMS_OFS_CTRL, 32'h1, 32'h0);
    sw_reset_in <= 1'b1;
    @(posedge mclk);
    sw_reset_in <= 1'b0;
    wdog_reset_in <= 1'b1;
    @(posedge mclk);
    wdog_reset_in <= 1'b0;
    rdc("reset causes", `SMS_OFS_RCAUSE, 32'h7, 32'h7);
    $display("test hard reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, main_cmd, batt_cmd, sw_reset_in, wdog_reset_in} = 7'h00;
    {paddr, pwdata, gpio_in, rtc_alarm_in} = 69'h0;
    hard_reset_in_n = 1'b1;
    mem_idle_in = 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_force;
    t_fault;
    t_hard;
    end_sim;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    end_sim;
  end
endmodule
